// ==== design/sixteen_bit_interval_timer.sv ====
// Sixteen-bit interval timer with prescaler, rollover flag and Wishbone registers.
//
// Notes on behaviour
// RQ1 - Sixteen-bit up-counter seen as two bytes.
// RQ2 - Byte writes replace that counter byte immediately.
// RQ3 - Clock select: one system, zero instruction clock.
// RQ4 - Counter advances on prescaled selected clock.
// RQ5 - System clock unprescaled gives four per instruction.
// RQ6 - Prescale field selects 1, 2, 4, 8.
// RQ7 - Prescaler hidden, cleared by count byte writes.
// RQ8 - Wrap from all ones sets rollover flag.
// RQ9 - Interrupt needs all four enables set.
// RQ10 - Software clears the rollover flag itself.
// RQ11 - Software clears count and flag first.
// RQ12 - No counting during sleep, no wake.
// RQ13 - Enable bit clear stops and clears gate.
// RQ14 - Unused control bits ignore writes, read zero.
// RQ15 - Any reset clears the prescale counter.
// RQ16 - Disabled counter holds; byte writes still work.
`timescale 1ns/10ps
`default_nettype none
module sixteen_bit_interval_timer (
	input wire logic clk, // System clock, the counter's fast source.
	input wire logic rst_b, // Asynchronous reset, active low.
	input wire logic sleepReq, // Device sleep request from another clock.
	input wire interval_timer_pkg::wb_req_t wbReq, // Wishbone request.
	output var interval_timer_pkg::wb_rsp_t wbRsp, // Wishbone answer.
	output logic irq // Level interrupt.
);
	import interval_timer_pkg::*;

	// ----------------------------------------------------------------
	// State.
	// ----------------------------------------------------------------
	logic [15:0] count; // Live counter value.
	logic [7:0] control; // Control register, unused bits kept zero.
	logic [2:0] prescale; // Hidden prescale counter.
	logic [1:0] instrDiv; // Divider making the instruction tick.
	logic gate; // Gate flip-flop, cleared while disabled.
	logic rollFlag; // Sticky rollover flag.
	logic rollEnable; // Rollover interrupt enable.
	logic [1:0] coreEn; // Peripheral and global enables.
	logic sleepMeta; // First synchroniser stage.
	logic sleepSync; // Second synchroniser stage.

	// Sleep is asynchronous to us, so it is synchronised first.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sleepMeta <= 1'b0;
			sleepSync <= 1'b0;
		end else begin
			sleepMeta <= sleepReq;
			sleepSync <= sleepMeta;
		end
	end

	// ----------------------------------------------------------------
	// Bus decode.
	// ----------------------------------------------------------------
	wire busReq = wbReq.cyc && wbReq.stb && !wbRsp.ack; // New request, one ack each.
	wire busWr = busReq && wbReq.we && wbReq.sel[0]; // Low lane write.
	wire wrLow = busWr && (wbReq.adr == OFS_COUNT_LOW); // Low byte write.
	wire wrHigh = busWr && (wbReq.adr == OFS_COUNT_HIGH); // High byte write.
	wire wrCtl = busWr && (wbReq.adr == OFS_CONTROL); // Control write.
	wire wrClr = busWr && (wbReq.adr == OFS_IRQ_CLEAR); // Flag clear write.
	wire wrEn = busWr && (wbReq.adr == OFS_IRQ_ENABLE); // Enable write.
	wire wrCore = busWr && (wbReq.adr == OFS_CORE_IRQ); // Core enable write.
	wire countWrite = wrLow || wrHigh; // Either count byte written.

	// ----------------------------------------------------------------
	// Count tick generation.
	// ----------------------------------------------------------------
	wire running = control[CTL_ENABLE_POS] && !sleepSync; // RQ12 RQ13
	wire instrTick = (instrDiv == 2'(INSTR_DIV - 1)); // Instruction clock tick.
	wire srcTick = control[CTL_CLKSEL_POS] ? 1'b1 : instrTick; // RQ3 RQ5
	wire [1:0] prescSel = control[CTL_PRESC_LSB +: 2]; // Prescale select field.
	wire [2:0] prescMax = 3'((4'h1 << prescSel) - 4'h1); // RQ6
	// At or past the last count: lowering the ratio mid-run must not stall the counter.
	wire prescDone = (prescale >= prescMax); // RQ4 RQ6
	wire advance = running && gate && srcTick && prescDone; // RQ4
	wire wrap = advance && (count == 16'hffff); // RQ8
	wire [7:0] wrByte = wbReq.dat[7:0]; // Written byte.

	// Instruction divider runs freely except in sleep, like the core clock.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			instrDiv <= 2'h0;
		end else if (!sleepSync) begin
			instrDiv <= instrDiv + 2'h1;
		end
	end

	// Gate opens one cycle after enable; clearing enable closes it.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			gate <= 1'b0;
		end else begin
			gate <= control[CTL_ENABLE_POS]; // RQ13
		end
	end

	// Prescaler: reset clears it, a count byte write clears it.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prescale <= 3'h0; // RQ15
		end else if (countWrite) begin
			prescale <= 3'h0; // RQ7
		end else if (running && gate && srcTick) begin
			prescale <= prescDone ? 3'h0 : prescale + 3'h1; // RQ4
		end
	end

	// Counter: a byte write beats an advance in the same cycle.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= COUNT_RESET;
		end else if (wrLow) begin
			count[7:0] <= wrByte; // RQ2 RQ16
		end else if (wrHigh) begin
			count[15:8] <= wrByte; // RQ2 RQ16
		end else if (advance) begin
			count <= count + 16'h0001; // RQ1 RQ8
		end
	end

	// ----------------------------------------------------------------
	// Control and interrupt registers.
	// ----------------------------------------------------------------
	// Control takes only the implemented bits.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			control <= CONTROL_RESET;
			rollEnable <= 1'b0;
			coreEn <= 2'h0;
		end else begin
			if (wrCtl) begin
				control <= wrByte & CTL_WRITE_MASK; // RQ14
			end
			if (wrEn) begin
				rollEnable <= wrByte[ROLL_FLAG_POS];
			end
			if (wrCore) begin
				coreEn <= {wrByte[CORE_GLOBAL_POS], wrByte[CORE_PERIPH_POS]};
			end
		end
	end

	// Rollover flag: a wrap in the clearing cycle wins, so none is lost.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rollFlag <= 1'b0;
		end else if (wrap) begin
			rollFlag <= 1'b1; // RQ8
		end else if (wrClr && wrByte[ROLL_FLAG_POS]) begin
			rollFlag <= 1'b0; // RQ10
		end
	end

	// The interrupt needs the counter on as well as every enable.
	wire next_irq = rollFlag && rollEnable && control[CTL_ENABLE_POS]
		&& coreEn[0] && coreEn[1]; // RQ9

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else begin
			irq <= next_irq; // RQ9
		end
	end

	// ----------------------------------------------------------------
	// Read path and acknowledge.
	// ----------------------------------------------------------------
	// Unmapped addresses read zero and are still acknowledged.
	wire [7:0] rdByte =
		(wbReq.adr == OFS_COUNT_LOW) ? count[7:0] :
		(wbReq.adr == OFS_COUNT_HIGH) ? count[15:8] :
		(wbReq.adr == OFS_CONTROL) ? control :
		(wbReq.adr == OFS_IRQ_STATUS) ? {7'h00, rollFlag} :
		(wbReq.adr == OFS_IRQ_ENABLE) ? {7'h00, rollEnable} :
		(wbReq.adr == OFS_CORE_IRQ) ? {6'h00, coreEn} : 8'h00;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wbRsp <= '0;
		end else begin
			wbRsp.ack <= busReq;
			wbRsp.dat <= busReq ? {24'h000000, rdByte} : 32'h00000000;
		end
	end

	// ----------------------------------------------------------------
	// Assertions.
	// ----------------------------------------------------------------
	property p_wrap_sets_flag;
		@(posedge clk) disable iff (!rst_b)
		wrap |=> rollFlag;
	endproperty
	a_wrap_sets_flag: assert property (p_wrap_sets_flag) else $error("wrap lost flag"); // RQ8

	property p_wrap_zero;
		@(posedge clk) disable iff (!rst_b)
		wrap && !countWrite |=> count == 16'h0000;
	endproperty
	a_wrap_zero: assert property (p_wrap_zero) else $error("no wrap to zero"); // RQ8

	property p_hold_disabled;
		@(posedge clk) disable iff (!rst_b)
		!control[CTL_ENABLE_POS] && !countWrite |=> $stable(count);
	endproperty
	a_hold_disabled: assert property (p_hold_disabled) else $error("count moved"); // RQ13

	property p_sleep_hold;
		@(posedge clk) disable iff (!rst_b)
		sleepSync && !countWrite |=> $stable(count);
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("count in sleep"); // RQ12

	property p_presc_clear;
		@(posedge clk) disable iff (!rst_b)
		countWrite |=> prescale == 3'h0;
	endproperty
	a_presc_clear: assert property (p_presc_clear) else $error("prescaler kept"); // RQ7

	property p_low_write;
		@(posedge clk) disable iff (!rst_b)
		wrLow |=> count[7:0] == $past(wrByte);
	endproperty
	a_low_write: assert property (p_low_write) else $error("low write lost"); // RQ2

	property p_high_write;
		@(posedge clk) disable iff (!rst_b)
		wrHigh |=> count[15:8] == $past(wrByte);
	endproperty
	a_high_write: assert property (p_high_write) else $error("high write lost"); // RQ2

	property p_count_step;
		@(posedge clk) disable iff (!rst_b)
		advance && !countWrite |=> count == $past(count) + 16'h0001;
	endproperty
	a_count_step: assert property (p_count_step) else $error("count step wrong"); // RQ1

	property p_gate_clear;
		@(posedge clk) disable iff (!rst_b)
		!control[CTL_ENABLE_POS] |=> !gate;
	endproperty
	a_gate_clear: assert property (p_gate_clear) else $error("gate left open"); // RQ13

	property p_slow_gap;
		@(posedge clk) disable iff (!rst_b)
		advance && !control[CTL_CLKSEL_POS] && !wrCtl |=> !advance;
	endproperty
	a_slow_gap: assert property (p_slow_gap) else $error("slow source too fast"); // RQ3

	property p_presc_gap;
		@(posedge clk) disable iff (!rst_b)
		advance && control[CTL_CLKSEL_POS] && prescSel == 2'h3 && !wrCtl |=> !advance;
	endproperty
	a_presc_gap: assert property (p_presc_gap) else $error("divide by eight too fast"); // RQ6

	property p_flag_sticky;
		@(posedge clk) disable iff (!rst_b)
		rollFlag && !(wrClr && wrByte[ROLL_FLAG_POS]) |=> rollFlag;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped"); // RQ10

	property p_irq_needs_on;
		@(posedge clk) disable iff (!rst_b)
		!control[CTL_ENABLE_POS] |=> !irq;
	endproperty
	a_irq_needs_on: assert property (p_irq_needs_on) else $error("irq while stopped"); // RQ9

	property p_fast_four;
		@(posedge clk) disable iff (!rst_b)
		running && gate && control[CTL_CLKSEL_POS] && prescSel == 2'h0 && !countWrite
		##1 (running && control[CTL_CLKSEL_POS] && prescSel == 2'h0 && !countWrite) [*3]
		|=> count == $past(count, 4) + 16'h0004;
	endproperty
	a_fast_four: assert property (p_fast_four) else $error("not four per cycle"); // RQ5

	property p_irq_gate;
		@(posedge clk) disable iff (!rst_b)
		irq |-> $past(rollFlag && rollEnable && coreEn == 2'h3);
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq without enables"); // RQ9

	property p_ctl_unused;
		@(posedge clk) disable iff (!rst_b)
		(control & ~CTL_WRITE_MASK) == 8'h00;
	endproperty
	a_ctl_unused: assert property (p_ctl_unused) else $error("unused bits set"); // RQ14

	property p_ack_pulse;
		@(posedge clk) disable iff (!rst_b)
		wbRsp.ack |=> !wbRsp.ack;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");

	c_wrap: cover property (@(posedge clk) disable iff (!rst_b) wrap);
	c_irq: cover property (@(posedge clk) disable iff (!rst_b) $rose(irq));
	c_slow_div8: cover property (@(posedge clk) disable iff (!rst_b)
		advance && prescSel == 2'h3 && !control[CTL_CLKSEL_POS]);
	c_clear_race: cover property (@(posedge clk) disable iff (!rst_b) wrap && wrClr);
endmodule : sixteen_bit_interval_timer
`default_nettype wire

// ==== pkg/interval_timer_pkg.sv ====
// Package with register map, field layout and bus types for the interval timer.
package interval_timer_pkg;
	// ----------------------------------------------------------------
	// Register offsets (byte addresses, one aligned word each).
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_COUNT_LOW = 8'h00; // Low count byte.
	localparam logic [7:0] OFS_COUNT_HIGH = 8'h04; // High count byte.
	localparam logic [7:0] OFS_CONTROL = 8'h08; // Timer control register.
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c; // Sticky status, read only.
	localparam logic [7:0] OFS_IRQ_CLEAR = 8'h10; // Write one to clear.
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14; // Enable, same layout.
	localparam logic [7:0] OFS_CORE_IRQ = 8'h18; // Global and peripheral enables.
	// ----------------------------------------------------------------
	// Field positions and reset values.
	// ----------------------------------------------------------------
	localparam int CTL_ENABLE_POS = 0; // Count enable bit.
	localparam int CTL_CLKSEL_POS = 1; // Clock select bit.
	localparam int CTL_PRESC_LSB = 4; // Prescale select field, bits 5 to 4.
	localparam logic [7:0] CTL_WRITE_MASK = 8'h33; // Implemented control bits.
	localparam logic [7:0] CONTROL_RESET = 8'h00; // Control value after reset.
	localparam int ROLL_FLAG_POS = 0; // Rollover flag in status layout.
	localparam int CORE_PERIPH_POS = 0; // Peripheral enable in core register.
	localparam int CORE_GLOBAL_POS = 1; // Global enable in core register.
	localparam logic [15:0] COUNT_RESET = 16'h0000; // Counter after reset.
	// ----------------------------------------------------------------
	// Timing.
	// ----------------------------------------------------------------
	localparam int SYS_CLK_MHZ = 8; // System clock rate.
	localparam int INSTR_CLK_MHZ = 2; // Instruction clock rate.
	localparam int INSTR_DIV = SYS_CLK_MHZ / INSTR_CLK_MHZ; // Four.
	// ----------------------------------------------------------------
	// Wishbone request carrier.
	// ----------------------------------------------------------------
	typedef struct packed {
		logic cyc; // Cycle.
		logic stb; // Strobe.
		logic we; // Write enable.
		logic [3:0] sel; // Byte selects.
		logic [7:0] adr; // Byte address.
		logic [31:0] dat; // Write data.
	} wb_req_t;
	typedef struct packed {
		logic ack; // Acknowledge.
		logic [31:0] dat; // Read data.
	} wb_rsp_t;
endpackage : interval_timer_pkg

// ==== sim/tb.sv ====
// Self-checking bench for the sixteen-bit interval timer over its Wishbone registers.
`timescale 1ns/10ps
`default_nettype none
module tb;
	import interval_timer_pkg::*;
	logic clk; // Bench clock, 125 MHz.
	logic rst_b; // Reset, active low.
	logic sleepReq; // Sleep level into the timer.
	wb_req_t wbReq; // Bus request from the bench.
	wb_rsp_t wbRsp; // Bus answer from the timer.
	logic irq; // Interrupt level.
	int fail_count; // Mismatches seen.
	int cmp_count; // Comparisons made.
	logic [31:0] rd; // Earlier sample in a rate test.
	logic [31:0] q; // Later sample in a rate test.
	logic [7:0] tbl [4][3]; // Enable table: address, masking value, full value.

	sixteen_bit_interval_timer u_sixteen_bit_interval_timer (
		.clk(clk),
		.rst_b(rst_b),
		.sleepReq(sleepReq),
		.wbReq(wbReq),
		.wbRsp(wbRsp),
		.irq(irq)
	);

	// ----
	// Bus and check tasks.
	// ----
	// One classic cycle; the request stands until ack is sampled high, then one idle cycle.
	// Only the watchdog ends a wait that never sees ack.
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
			output logic [31:0] r);
		wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hf, adr: a, dat: {24'h000000, d}};
		do begin
			@(posedge clk);
		end while (wbRsp.ack !== 1'b1);
		r = wbRsp.dat;
		wbReq <= '0;
		@(posedge clk);
	endtask : bus
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask : wr
	task automatic rdChk(input string name, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, a, 8'h00, r);
		check(name, r, exp);
	endtask : rdChk
	// The level settles within two cycles; look after the edge, then realign to an edge.
	task automatic irqChk(input logic exp);
		repeat (3) @(posedge clk);
		#1;
		check("irq", {31'h0, irq}, {31'h0, exp});
		@(posedge clk);
	endtask : irqChk
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize

	// ----
	// Clock, watchdog and tests.
	// ----
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// The whole run is under two thousand cycles, so this limit only trips on a hang.
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		summarize();
	end
	initial begin
		rst_b = 1'b0;
		sleepReq = 1'b0;
		wbReq = '0;
		fail_count = 0;
		cmp_count = 0;
		tbl = '{'{8'h08, 8'h02, 8'h03}, '{8'h14, 8'h00, 8'h01}, '{8'h18, 8'h02, 8'h03}, '{8'h18, 8'h01, 8'h03}};
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rdChk("control", OFS_CONTROL, 32'h0);
		rdChk("low", OFS_COUNT_LOW, 32'h0);
		rdChk("status", OFS_IRQ_STATUS, 32'h0);
		rdChk("unmapped", 8'h1c, 32'h0);
		wr(OFS_CONTROL, 8'hfe);
		rdChk("control", OFS_CONTROL, 32'h32);
		$display("test reset and control done");
		// Stopped counter keeps written bytes.
		wr(OFS_CONTROL, 8'h32);
		wr(OFS_COUNT_LOW, 8'h5a);
		wr(OFS_COUNT_HIGH, 8'ha5);
		repeat (40) @(posedge clk);
		rdChk("low", OFS_COUNT_LOW, 32'h5a);
		rdChk("high", OFS_COUNT_HIGH, 32'ha5);
		$display("test hold done");
		// Reads 128 cycles apart; 128 is a multiple of every period, so the gain is exact.
		for (int cs = 0; cs < 2; cs++) begin
			for (int ps = 0; ps < 4; ps++) begin
				wr(OFS_CONTROL, {2'b00, 2'(ps), 2'b00, 1'(cs), 1'b1});
				repeat (40) @(posedge clk);
				bus(1'b0, OFS_COUNT_LOW, 8'h00, rd);
				repeat (125) @(posedge clk);
				bus(1'b0, OFS_COUNT_LOW, 8'h00, q);
				check("gain", {24'h0, q[7:0] - rd[7:0]}, 32'd128 >> (ps + (cs == 0 ? 2 : 0)));
			end
		end
		$display("test rates done");
		// Rewrites every three cycles keep a 1:8 prescaler from ever reaching its count.
		wr(OFS_CONTROL, 8'h33);
		wr(OFS_COUNT_HIGH, 8'h00);
		repeat (10) wr(OFS_COUNT_LOW, 8'h10);
		rdChk("low", OFS_COUNT_LOW, 32'h10);
		// A cleared 1:8 prescaler steps the count exactly eight cycles after the write.
		wr(OFS_COUNT_LOW, 8'h10);
		repeat (5) @(posedge clk);
		rdChk("presc8", OFS_COUNT_LOW, 32'h10);
		rdChk("presc9", OFS_COUNT_LOW, 32'h11);
		sleepReq <= 1'b1;
		repeat (5) @(posedge clk);
		wr(OFS_COUNT_LOW, 8'h20);
		repeat (125) @(posedge clk);
		rdChk("sleep", OFS_COUNT_LOW, 32'h20);
		sleepReq <= 1'b0;
		$display("test prescaler clear and sleep done");
		// Wrap from all ones with every enable set.
		wr(OFS_CONTROL, 8'h02);
		wr(OFS_IRQ_CLEAR, 8'h01);
		wr(OFS_COUNT_LOW, 8'hf0);
		wr(OFS_COUNT_HIGH, 8'hff);
		wr(OFS_IRQ_ENABLE, 8'h01);
		wr(OFS_CORE_IRQ, 8'h03);
		irqChk(1'b0);
		wr(OFS_CONTROL, 8'h03);
		repeat (30) @(posedge clk);
		rdChk("status", OFS_IRQ_STATUS, 32'h1);
		rdChk("high", OFS_COUNT_HIGH, 32'h0);
		irqChk(1'b1);
		wr(OFS_IRQ_STATUS, 8'h00);
		rdChk("status", OFS_IRQ_STATUS, 32'h1);
		// Dropping any one enable masks the level but leaves the flag.
		foreach (tbl[i]) begin
			wr(tbl[i][0], tbl[i][1]);
			irqChk(1'b0);
			wr(tbl[i][0], tbl[i][2]);
			irqChk(1'b1);
		end
		wr(OFS_IRQ_CLEAR, 8'h01);
		rdChk("status", OFS_IRQ_STATUS, 32'h0);
		irqChk(1'b0);
		$display("test rollover done");
		summarize();
	end
endmodule : tb
`default_nettype wire
